// ===== include/ibe_pkg.sv
package ibe_pkg;
  // Engine states
  typedef enum logic [3:0] {
    IBE_IDLE  = 4'b0000,
    IBE_ST_A  = 4'b0001,
    IBE_ST_B  = 4'b0010,
    IBE_RS_A  = 4'b0011,
    IBE_RS_B  = 4'b0100,
    IBE_RS_C  = 4'b0101,
    IBE_TX_LO = 4'b0110,
    IBE_TX_HI = 4'b0111,
    IBE_RX_LO = 4'b1000,
    IBE_RX_HI = 4'b1001,
    IBE_AK_LO = 4'b1010,
    IBE_AK_HI = 4'b1011,
    IBE_SP_A  = 4'b1100,
    IBE_SP_B  = 4'b1101,
    IBE_SP_C  = 4'b1110
  } ibe_state_t;
  localparam int         IBE_DW        = 8;
  localparam logic [3:0] IBE_BIT_FIRST = 4'h0;
  localparam logic [3:0] IBE_BIT_LAST  = 4'h7;
  localparam logic [3:0] IBE_BIT_ACK   = 4'h8;
  localparam logic [3:0] IBE_BIT_STEP  = 4'h1;
  localparam logic [7:0] IBE_CNT_ZERO  = 8'h00;
  localparam logic [7:0] IBE_CNT_STEP  = 8'h01;
  localparam logic [7:0] IBE_BYTE_RST  = 8'h00;
endpackage : ibe_pkg

// ===== src/ibe_master.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Buffer full sets on buffer load, clears after eighth bit shifted out.
// - Buffer write while engine busy is dropped and sets write collision.
// - Ack status clears on slave ack low, sets on high.
// - Event flag rises at end of ninth clock after each sent byte.
// - Buffer write after Start shifts all eight bits out, one per clock, MSB first.
// - Receive request ignored unless engine idle and receive buffer has room.
// - Receiving: each baud rollover toggles SCL; SDA shifted in each clock.
// - After eighth receive fall: clear enable, store byte, flags, hold SCL low.
// - Reading the received byte clears buffer full unless a second byte waits.
// - Overflow sets when a byte completes while buffer full still set.
// - Ack: SCL low, drive ack value, release after period, wait one more.
// - Ack end: SCL low, clear ack request, stop baud, go idle.
// - Stop: SDA low, then baud period, release SCL, then SDA later.
// - SDA high with SCL high marks stop; a period later clear request, event.
// - Reset or disable aborts transfer, clears start and stop detected.
// - SDA low while expected high with SCL high: collision, go idle.
// - Collision in transmit: halt, clear buffer full, release lines.
// - Collision in a sequence: abort, release lines, clear its request.
// - After lost arbitration keep watching; stop condition raises event.
// - Buffer write after collision starts again from the first bit.
// - Start: SDA low after one period, clear request after another.
// - Released SCL halts baud count until SCL reads high, then reloads.
module ibe_master (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  // Configuration
  input  wire logic              ENABLE,
  input  wire logic [7:0]        BAUD_RELOAD,
  input  wire logic              ACK_DATA,
  // Sequence requests, one-cycle pulses
  input  wire logic              START_REQ,
  input  wire logic              RESTART_REQ,
  input  wire logic              STOP_REQ,
  input  wire logic              RECEIVE_REQ,
  input  wire logic              ACK_REQ,
  // Transmit buffer write
  input  wire logic              BUF_WR,
  input  wire logic [ibe_pkg::IBE_DW-1:0] BUF_WDATA,
  // Received byte stream
  output var  logic              RX_VALID,
  output var  logic [ibe_pkg::IBE_DW-1:0] RX_DATA,
  input  wire logic              RX_READY,
  // Flag clears, one-cycle pulses
  input  wire logic              CLR_WRITE_COLLISION_FLAG,
  input  wire logic              CLR_OVF,
  input  wire logic              CLR_EVENT,
  input  wire logic              CLR_BCOL,
  // Status
  output var  logic              START_BIT,
  output var  logic              RESTART_BIT,
  output var  logic              STOP_BIT,
  output var  logic              RECEIVE_BIT,
  output var  logic              ACK_SEQ_BIT,
  output var  logic              BUF_FULL,
  output var  logic              WRITE_COLLISION_FLAG,
  output var  logic              ACK_STAT,
  output var  logic              OVF,
  output var  logic              EVENT,
  output var  logic              BCOL,
  output var  logic              START_DET,
  output var  logic              STOP_DET,
  // Bus pins
  input  wire logic              SDA_I,
  output var  logic              SDA_O,
  output var  logic              SDA_OE,
  input  wire logic              SCL_I,
  output var  logic              SCL_O,
  output var  logic              SCL_OE
);
  import ibe_pkg::*;

  ibe_state_t  state;
  logic [7:0]  cnt;
  logic [3:0]  bitn;
  logic [7:0]  shifter;
  logic        sda_m, sda_s, sda_p, scl_m, scl_s;
  logic        tx_full, lost;
  logic        v1;
  logic [7:0]  e1;

  // Pin synchronisers; sda_p is a delayed copy for edge finding
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      {sda_m, sda_s, sda_p} <= 3'h7;
      {scl_m, scl_s}        <= 2'h3;
    end else begin
      {sda_m, sda_s, sda_p} <= {SDA_I, sda_m, sda_s};
      {scl_m, scl_s}        <= {SCL_I, scl_m};
    end
  end

  // Decodes
  wire idle      = (state == IBE_IDLE);
  wire tick      = (cnt == IBE_CNT_ZERO);
  wire start_see = scl_s && sda_p && !sda_s;
  wire stop_see  = scl_s && !sda_p && sda_s;
  wire rx_room   = !v1;
  wire pop       = RX_VALID && RX_READY;
  wire scl_wait  = !SCL_OE && !scl_s;
  wire sp_wait   = (state == IBE_SP_A) && sda_s;
  wire rx_push   = (state == IBE_RX_HI) && tick && (bitn == IBE_BIT_LAST);
  wire [7:0] rx_byte = {shifter[6:0], sda_s};
  wire tx_bit    = shifter[7];
  wire acc_wr    = BUF_WR && idle && ENABLE;
  wire rx_go     = RECEIVE_REQ && idle && rx_room;
  // Collision when a released SDA reads low while SCL is high, or when SCL or SDA reads low before a Start
  wire coll_tx   = (state == IBE_TX_HI) && scl_s && !SDA_OE && !sda_s
                   && (bitn != IBE_BIT_ACK);
  wire coll_ak   = (state == IBE_AK_HI) && scl_s && !SDA_OE && !sda_s;
  wire coll_st   = (state == IBE_ST_A) && (!scl_s || !sda_s);
  wire coll_rs   = (state == IBE_RS_B) && tick && !sda_s;
  wire coll_sp   = (state == IBE_SP_C) && tick && !sda_s;
  wire coll      = coll_tx || coll_ak || coll_st || coll_rs || coll_sp;

  // Baud generator: reload on entry or rollover, hold while SCL stretched
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= IBE_CNT_ZERO;
    end else if (idle || tick || scl_wait || sp_wait) begin
      cnt <= BAUD_RELOAD;
    end else begin
      cnt <= cnt - IBE_CNT_STEP;
    end
  end

  // Sticky flags, a set wins over its clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_COLLISION_FLAG <= 1'b0;
      OVF  <= 1'b0;
      BCOL <= 1'b0;
    end else begin
      WRITE_COLLISION_FLAG <= (BUF_WR && !idle) || (WRITE_COLLISION_FLAG && !CLR_WRITE_COLLISION_FLAG);
      OVF  <= (rx_push && RX_VALID) || (OVF && !CLR_OVF);
      BCOL <= coll || (BCOL && !CLR_BCOL);
    end
  end

  // Start and stop watchers, cleared while disabled
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      START_DET <= 1'b0;
      STOP_DET  <= 1'b0;
    end else if (!ENABLE) begin
      START_DET <= 1'b0;
      STOP_DET  <= 1'b0;
    end else if (start_see) begin
      START_DET <= 1'b1;
      STOP_DET  <= 1'b0;
    end else if (stop_see) begin
      START_DET <= 1'b0;
      STOP_DET  <= 1'b1;
    end
  end

  // Two-entry receive buffer; head sits on the output ports
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RX_VALID <= 1'b0;
      RX_DATA  <= IBE_BYTE_RST;
      v1       <= 1'b0;
      e1       <= IBE_BYTE_RST;
    end else if (!ENABLE) begin
      RX_VALID <= 1'b0;
      v1       <= 1'b0;
    end else begin
      if (pop) begin
        RX_VALID <= v1 || rx_push;
        RX_DATA  <= v1 ? e1 : rx_byte;
        v1       <= v1 && rx_push;
        e1       <= rx_byte;
      end else if (rx_push && !RX_VALID) begin
        RX_VALID <= 1'b1;
        RX_DATA  <= rx_byte;
      end else if (rx_push) begin
        v1 <= 1'b1;
        e1 <= rx_byte;
      end
    end
  end

  // Buffer full covers an unsent byte or an unread received byte
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BUF_FULL <= 1'b0;
    end else begin
      BUF_FULL <= acc_wr || (tx_full && !(state == IBE_TX_HI && tick
                  && bitn == IBE_BIT_LAST) && !coll)
                  || rx_push || v1 || (RX_VALID && !pop);
    end
  end

  // Master engine
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state       <= IBE_IDLE;
      bitn        <= IBE_BIT_FIRST;
      shifter     <= IBE_BYTE_RST;
      tx_full     <= 1'b0;
      lost        <= 1'b0;
      SDA_OE      <= 1'b0;
      SCL_OE      <= 1'b0;
      SDA_O       <= 1'b0;
      SCL_O       <= 1'b0;
      START_BIT   <= 1'b0;
      RESTART_BIT <= 1'b0;
      STOP_BIT    <= 1'b0;
      RECEIVE_BIT <= 1'b0;
      ACK_SEQ_BIT <= 1'b0;
      ACK_STAT    <= 1'b0;
      EVENT       <= 1'b0;
    end else if (!ENABLE) begin
      state       <= IBE_IDLE;
      tx_full     <= 1'b0;
      lost        <= 1'b0;
      SDA_OE      <= 1'b0;
      SCL_OE      <= 1'b0;
      START_BIT   <= 1'b0;
      RESTART_BIT <= 1'b0;
      STOP_BIT    <= 1'b0;
      RECEIVE_BIT <= 1'b0;
      ACK_SEQ_BIT <= 1'b0;
      EVENT       <= EVENT && !CLR_EVENT;
    end else if (coll) begin
      state       <= IBE_IDLE;
      tx_full     <= 1'b0;
      lost        <= 1'b1;
      SDA_OE      <= 1'b0;
      SCL_OE      <= 1'b0;
      START_BIT   <= 1'b0;
      RESTART_BIT <= 1'b0;
      STOP_BIT    <= 1'b0;
      ACK_SEQ_BIT <= 1'b0;
      EVENT       <= EVENT && !CLR_EVENT;
    end else begin
      EVENT <= (lost && stop_see) || (EVENT && !CLR_EVENT);
      if (lost && stop_see) begin
        lost <= 1'b0;
      end
      case (state)
        IBE_IDLE: begin
          if (acc_wr) begin
            shifter <= BUF_WDATA;
            bitn    <= IBE_BIT_FIRST;
            tx_full <= 1'b1;
            state   <= IBE_TX_LO;
          end else if (START_REQ) begin
            START_BIT <= 1'b1;
            state     <= IBE_ST_A;
          end else if (RESTART_REQ) begin
            RESTART_BIT <= 1'b1;
            state       <= IBE_RS_A;
          end else if (STOP_REQ) begin
            STOP_BIT <= 1'b1;
            state    <= IBE_SP_A;
          end else if (rx_go) begin
            RECEIVE_BIT <= 1'b1;
            bitn        <= IBE_BIT_FIRST;
            state       <= IBE_RX_LO;
          end else if (ACK_REQ) begin
            ACK_SEQ_BIT <= 1'b1;
            state       <= IBE_AK_LO;
          end
        end
        IBE_ST_A: if (tick) begin
          SDA_OE <= 1'b1;
          state  <= IBE_ST_B;
        end
        IBE_ST_B: if (tick) begin
          START_BIT <= 1'b0;
          EVENT     <= 1'b1;
          state     <= IBE_IDLE;
        end
        IBE_RS_A: begin
          SCL_OE <= 1'b1;
          SDA_OE <= 1'b0;
          if (tick) begin
            SCL_OE <= 1'b0;
            state  <= IBE_RS_B;
          end
        end
        IBE_RS_B: if (tick) begin
          SDA_OE <= 1'b1;
          state  <= IBE_RS_C;
        end
        IBE_RS_C: if (tick) begin
          SCL_OE      <= 1'b1;
          RESTART_BIT <= 1'b0;
          EVENT       <= 1'b1;
          state       <= IBE_IDLE;
        end
        IBE_TX_LO: begin
          SCL_OE <= 1'b1;
          SDA_OE <= (bitn == IBE_BIT_ACK) ? 1'b0 : !tx_bit;
          if (tick) begin
            SCL_OE <= 1'b0;
            state  <= IBE_TX_HI;
          end
        end
        IBE_TX_HI: if (tick) begin
          SCL_OE <= 1'b1;
          if (bitn == IBE_BIT_ACK) begin
            ACK_STAT <= sda_s;
            EVENT    <= 1'b1;
            state    <= IBE_IDLE;
          end else begin
            if (bitn == IBE_BIT_LAST) begin
              tx_full <= 1'b0;
            end
            shifter <= {shifter[6:0], 1'b0};
            bitn    <= bitn + IBE_BIT_STEP;
            state   <= IBE_TX_LO;
          end
        end
        IBE_RX_LO: begin
          SCL_OE <= 1'b1;
          SDA_OE <= 1'b0;
          if (tick) begin
            SCL_OE <= 1'b0;
            state  <= IBE_RX_HI;
          end
        end
        IBE_RX_HI: if (tick) begin
          SCL_OE  <= 1'b1;
          shifter <= rx_byte;
          bitn    <= bitn + IBE_BIT_STEP;
          state   <= IBE_RX_LO;
          if (bitn == IBE_BIT_LAST) begin
            RECEIVE_BIT <= 1'b0;
            EVENT       <= 1'b1;
            state       <= IBE_IDLE;
          end
        end
        IBE_AK_LO: begin
          SCL_OE <= 1'b1;
          SDA_OE <= !ACK_DATA;
          if (tick) begin
            SCL_OE <= 1'b0;
            state  <= IBE_AK_HI;
          end
        end
        IBE_AK_HI: if (tick) begin
          SCL_OE      <= 1'b1;
          ACK_SEQ_BIT <= 1'b0;
          EVENT       <= 1'b1;
          state       <= IBE_IDLE;
        end
        IBE_SP_A: begin
          SCL_OE <= 1'b1;
          SDA_OE <= 1'b1;
          if (tick) begin
            SCL_OE <= 1'b0;
            state  <= IBE_SP_B;
          end
        end
        IBE_SP_B: if (tick) begin
          SDA_OE <= 1'b0;
          state  <= IBE_SP_C;
        end
        IBE_SP_C: if (tick) begin
          STOP_BIT <= 1'b0;
          EVENT    <= 1'b1;
          state    <= IBE_IDLE;
        end
        default: state <= IBE_IDLE;
      endcase
    end
  end
endmodule : ibe_master
`default_nettype wire

// ===== testbench/ibe_master_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ibe_master_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Controls
  input wire logic ENABLE,
  input wire logic ACK_DATA,
  input wire logic BUF_WR,
  // Status
  input wire logic START_BIT,
  input wire logic STOP_BIT,
  input wire logic RECEIVE_BIT,
  input wire logic ACK_SEQ_BIT,
  input wire logic WRITE_COLLISION_FLAG,
  input wire logic EVENT,
  input wire logic BCOL,
  input wire logic RX_VALID,
  input wire logic STOP_DET,
  // Line pulls
  input wire logic SDA_OE,
  input wire logic SCL_OE
);
  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // Refusal and reset behaviour
  write_collision_flag_busy_a: assert property (
    BUF_WR && (START_BIT || STOP_BIT || RECEIVE_BIT || ACK_SEQ_BIT) |=> WRITE_COLLISION_FLAG)
    else $error("busy write not refused");
  rst_quiet_a: assert property (
    $rose(RST_N) |-> !SDA_OE && !SCL_OE && !BCOL && !STOP_DET)
    else $error("lines or flags active after reset");
  off_clears_a: assert property (
    !ENABLE ##1 !ENABLE |-> !STOP_DET && !SDA_OE && !SCL_OE)
    else $error("disable left state behind");
  // Sequence endings, acknowledge level and collision release
  start_end_a: assert property (
    $fell(START_BIT) && $past(ENABLE) && !BCOL |-> EVENT && SDA_OE)
    else $error("start ended badly");
  stop_end_a: assert property (
    $fell(STOP_BIT) && $past(ENABLE) && !BCOL |-> EVENT && STOP_DET && !SDA_OE && !SCL_OE)
    else $error("stop ended badly");
  rx_end_a: assert property (
    $fell(RECEIVE_BIT) && $past(ENABLE) && !BCOL |-> EVENT && RX_VALID && SCL_OE)
    else $error("receive ended badly");
  ack_value_a: assert property (
    $rose(ACK_SEQ_BIT) ##2 ACK_SEQ_BIT |-> SDA_OE != ACK_DATA)
    else $error("wrong acknowledge level");
  bcol_free_a: assert property (
    $rose(BCOL) |-> ##[0:1] !SDA_OE && !SCL_OE)
    else $error("lines held after collision");
  // Main scenarios
  rx_done_c: cover property ($fell(RECEIVE_BIT));
  bcol_c: cover property ($rose(BCOL));
  stop_c: cover property ($fell(STOP_BIT));
endmodule : ibe_master_asserts
`default_nettype wire

// ===== testbench/ibe_master_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ibe_master_tb;
  import ibe_pkg::*;
  // Bench drive and observe signals
  logic              clock, rst_n, enable, ack_data, rdy, nack, rd, jam, stretch;
  logic [5:0]        req;
  logic [3:0]        clr;
  logic [IBE_DW-1:0] wdata, sbyte, got, rx_data;
  logic [31:0]       rnd;
  logic              rx_valid, start_bit, restart_bit, stop_bit, receive_bit, ack_seq_bit;
  logic              buf_full, write_collision_flag, ack_stat, ovf, evt, bcol, start_det, stop_det;
  logic              sda_oe, scl_oe, s_sda_oe, s_scl_oe;
  logic [7:0]        expq[$];
  int                errors = 0;
  int                checks_done = 0;
  // Open-drain lines with pull-ups
  wire logic         sda = !(sda_oe || s_sda_oe);
  wire logic         scl = !(scl_oe || s_scl_oe);

  ibe_master ibe_master_i (
    .CLOCK(clock), .RST_N(rst_n), .ENABLE(enable), .BAUD_RELOAD(8'h02),
    .ACK_DATA(ack_data), .START_REQ(req[0]), .RESTART_REQ(req[1]), .STOP_REQ(req[2]),
    .RECEIVE_REQ(req[3]), .ACK_REQ(req[4]), .BUF_WR(req[5]), .BUF_WDATA(wdata),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rdy), .CLR_WRITE_COLLISION_FLAG(clr[0]),
    .CLR_OVF(clr[1]), .CLR_EVENT(clr[2]), .CLR_BCOL(clr[3]), .START_BIT(start_bit),
    .RESTART_BIT(restart_bit), .STOP_BIT(stop_bit), .RECEIVE_BIT(receive_bit),
    .ACK_SEQ_BIT(ack_seq_bit), .BUF_FULL(buf_full), .WRITE_COLLISION_FLAG(write_collision_flag), .ACK_STAT(ack_stat),
    .OVF(ovf), .EVENT(evt), .BCOL(bcol), .START_DET(start_det), .STOP_DET(stop_det),
    .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe));

  ibe_slave_model ibe_slave_model_i (
    .scl(scl), .sda(sda), .nack(nack), .rd(rd), .jam(jam), .stretch(stretch),
    .tx_byte(sbyte), .got(got), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe));

  // System clock, 10 ns period
  always #5 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // Clear flags, pulse one request, poke mid-sequence, wait for the end
  task automatic op(input int k, input logic [7:0] d, input logic [5:0] pk);
    int   n;
    logic done;
    n = 0;
    clr <= 4'hF;
    wdata <= d;
    @(posedge clock);
    clr <= 4'h0;
    req <= 6'h01 << k;
    @(posedge clock);
    req <= 6'h00;
    wdata <= ~d;
    do begin
      @(posedge clock);
      n++;
      req <= (n == 3) ? pk : 6'h00;
      done = (k == 1) ? restart_bit === 1'b0 : (k == 4) ? ack_seq_bit === 1'b0
             : (evt === 1'b1 || bcol === 1'b1);
    end while (!done && n < 5000);
    if (!done) begin
      errors++;
      test_done();
    end
  endtask : op

  // Each popped byte against the oldest expectation
  always @(posedge clock)
    if (rx_valid === 1'b1 && rdy === 1'b1) chk("rx data", rx_data, expq.pop_front());

  // Watchdog
  initial begin
    #500000;
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    clock = 1'b0;
    {rst_n, ack_data, rdy, nack, rd, jam, stretch} = '0;
    enable = 1'b1;
    {req, clr, wdata, sbyte} = '0;
    rnd = 32'hCB29B0A2;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk("idle", {sda_oe, scl_oe, bcol, start_det, stop_det}, 8'h00);
    $display("reset test done");
    op(0, 8'h00, 6'h00);
    chk("start", {start_bit, sda_oe, start_det}, 8'h03);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      nack <= i[0];
      stretch <= i[0];
      op(5, rnd[7:0], 6'h28);
      chk("tx byte", got, rnd[7:0]);
      chk("ack stat", {7'h00, ack_stat}, {7'h00, i[0]});
      chk("tx event", {7'h00, evt, bcol}, 8'h02);
      chk("tx flags", {buf_full, write_collision_flag, receive_bit}, 8'h02);
    end
    stretch <= 1'b0;
    nack <= 1'b0;
    op(1, 8'h00, 6'h00);
    rnd = lfsr(rnd);
    op(5, rnd[7:0] | 8'h01, 6'h00);
    $display("transmit test done");
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      rd <= 1'b1;
      sbyte <= rnd[7:0];
      expq.push_back(rnd[7:0]);
      ack_data <= i[0];
      op(3, 8'h00, 6'h20);
      chk("rx flags", {buf_full, write_collision_flag, ovf}, {5'h00, 2'b11, i[0]});
      op(4, 8'h00, 6'h20);
      chk("ack end", {ack_seq_bit, scl_oe, write_collision_flag}, 8'h03);
      // Slave stops driving only once the master's acknowledge bit is over
      rd <= !i[0];
    end
    req <= 6'h08;
    @(posedge clock);
    req <= 6'h00;
    repeat (2) @(posedge clock);
    chk("rx refused", {7'h00, receive_bit}, 8'h00);
    rdy <= 1'b1;
    repeat (6) @(posedge clock);
    chk("rx left", 8'(expq.size()), 8'h00);
    chk("rx empty", {7'h00, buf_full}, 8'h00);
    $display("receive test done");
    op(2, 8'h00, 6'h20);
    chk("stop", {stop_bit, stop_det, sda_oe, scl_oe, write_collision_flag}, 8'h09);
    op(0, 8'h00, 6'h00);
    jam <= 1'b1;
    op(5, 8'hFF, 6'h00);
    chk("collision", {bcol, buf_full, sda_oe, scl_oe}, 8'h08);
    jam <= 1'b0;
    repeat (8) @(posedge clock);
    chk("bus stop", {7'h00, evt}, 8'h01);
    op(0, 8'h00, 6'h00);
    rnd = lfsr(rnd);
    op(5, rnd[7:0], 6'h00);
    chk("resend", got, rnd[7:0]);
    op(2, 8'h00, 6'h00);
    $display("collision test done");
    enable <= 1'b0;
    repeat (3) @(posedge clock);
    chk("disabled", {start_det, stop_det, sda_oe, scl_oe}, 8'h00);
    $display("disable test done");
    test_done();
  end
endmodule : ibe_master_tb

bind ibe_master ibe_master_asserts ibe_master_asserts_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .ENABLE(ENABLE), .ACK_DATA(ACK_DATA), .BUF_WR(BUF_WR),
  .START_BIT(START_BIT), .STOP_BIT(STOP_BIT), .RECEIVE_BIT(RECEIVE_BIT),
  .ACK_SEQ_BIT(ACK_SEQ_BIT), .WRITE_COLLISION_FLAG(WRITE_COLLISION_FLAG), .EVENT(EVENT), .BCOL(BCOL),
  .RX_VALID(RX_VALID), .STOP_DET(STOP_DET), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE));
`default_nettype wire

// ===== testbench/ibe_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module ibe_slave_model (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour controls
  input  wire logic       nack,
  input  wire logic       rd,
  input  wire logic       jam,
  input  wire logic       stretch,
  input  wire logic [7:0] tx_byte,
  // Observed byte and line pulls
  output var  logic [7:0] got,
  output var  logic       sda_oe,
  output var  logic       scl_oe
);
  int         bitn = -1;
  logic [7:0] sh   = 8'h00;
  // Start or stop on the lines restarts the bit count
  always @(sda)
    if (scl === 1'b1) bitn = -1;
  // Count falling clocks, keep clock low a while when stretching
  always @(negedge scl) begin
    bitn = (bitn == 8) ? 0 : bitn + 1;
    if (bitn == 8) got = sh;
    if (stretch) begin
      scl_oe = 1'b1;
      #80;
    end
    scl_oe = 1'b0;
  end
  // Data bits sampled while the clock is high, MSB first
  always @(posedge scl)
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
  // Acknowledge, read data, or a competing master holding the line
  assign sda_oe = jam || (bitn == 8 && !rd && !nack)
                  || (rd && bitn >= 0 && bitn < 8 && !tx_byte[7 - bitn]);
endmodule : ibe_slave_model
`default_nettype wire
